//--- design/wwpl_kick_edge.sv
// kick input synchroniser and falling edge detector
`timescale 1ns/1ps
module wwpl_kick_edge (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic kick_input_i,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic last;

  // idle high so a kick held high at reset makes no edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= 1'b1;
      sync   <= 1'b1;
      last   <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      meta   <= kick_input_i;
      sync   <= meta;
      last   <= sync;
      fall_o <= last & ~sync;
    end
  end

  property p_single_pulse;
    @(posedge clock_i) disable iff (!rst_n_i)
      fall_o |=> !fall_o;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("kick edge pulse longer than one cycle");

endmodule

//--- design/wwpl_pkg.sv
// package for the window watchdog pin logic: constants, types, map
package wwpl_pkg;

  localparam int unsigned CLK_MHZ     = 32'h0000_000A;
  localparam int unsigned T_INIT_US   = 32'h0000_017D;
  localparam int unsigned T_SET_US    = 32'h0000_01F4;
  localparam int unsigned INIT_CYC    = T_INIT_US * CLK_MHZ;
  localparam int unsigned SET_CYC     = T_SET_US * CLK_MHZ;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CNT_W       = 32;

  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_INT_STAT = 8'h04;
  localparam logic [7:0] OFF_INT_MASK = 8'h08;

  localparam int unsigned EV_EARLY    = 0;
  localparam int unsigned EV_LATE     = 1;
  localparam int unsigned EV_RELEASE  = 2;
  localparam int unsigned EV_N        = 3;

  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_DIS_BIT   = 4;
  localparam int unsigned ST_PIN_BIT   = 5;

  localparam logic [EV_N-1:0] INT_MASK_RST = 3'h0;

  // select straps: 00 switches the watchdog off
  localparam logic [1:0] SEL_OFF      = 2'h0;
  localparam logic [1:0] SEL_HALF     = 2'h1;
  localparam logic [1:0] SEL_QUARTER  = 2'h2;
  localparam logic [1:0] SEL_EIGHTH   = 2'h3;
  localparam int unsigned SHIFT_HALF  = 1;
  localparam int unsigned SHIFT_QUART = 2;
  localparam int unsigned SHIFT_EIGHT = 3;

  // cap pin strap state
  localparam logic [1:0] CAP_CAPACITOR = 2'h0;
  localparam logic [1:0] CAP_OPEN      = 2'h1;
  localparam logic [1:0] CAP_PULLUP    = 2'h2;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_DIS,
    ST_CLOSED,
    ST_OPEN,
    ST_FAULT
  } wwpl_state_e;

  typedef struct packed {
    logic             off;
    logic [CNT_W-1:0] lower;
    logic [CNT_W-1:0] upper;
    logic [CNT_W-1:0] rst_dly;
  } wwpl_cfg_s;

  typedef struct packed {
    logic              sel;
    logic              en;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wwpl_apb_req_s;

endpackage

//--- design/wwpl_top.sv
// window watchdog core with apb status and interrupt registers
`timescale 1ns/1ps
module wwpl_top #(
  parameter logic [31:0] UPPER_CAP_CYC = 32'h0009_92C8,
  parameter logic [31:0] UPPER_NC_CYC  = 32'h000F_4240,
  parameter logic [31:0] UPPER_PU_CYC  = 32'h0098_9680,
  parameter logic [31:0] DLY_CAP_CYC   = 32'h0000_1B76,
  parameter logic [31:0] DLY_NC_CYC    = 32'h0000_2710,
  parameter logic [31:0] DLY_PU_CYC    = 32'h0001_86A0
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         kick_input_i,
  input  wire logic                         window_select_0_i,
  input  wire logic                         window_select_1_i,
  input  wire logic [1:0]                   timeout_cap_pin_i,
  input  wire logic [1:0]                   delay_cap_pin_i,
  input  wire logic                         fault_reset_output_i,
  output logic                              fault_reset_output_o,
  output logic                              fault_reset_output_oe_o,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [wwpl_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [wwpl_pkg::DATA_W-1:0]  pwdata_i,
  output logic      [wwpl_pkg::DATA_W-1:0]  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  output logic                              irq_o
);
  import wwpl_pkg::*;

  wwpl_state_e      state;
  wwpl_state_e      next_state;
  wwpl_cfg_s        cfg;
  wwpl_cfg_s        dec;
  wwpl_apb_req_s    req;
  logic [CNT_W-1:0] cnt;
  logic             kick_fall;
  logic             kick_live;
  logic             cfg_load;
  logic             restart;
  logic [EV_N-1:0]  ev;
  logic [EV_N-1:0]  int_stat;
  logic [EV_N-1:0]  int_mask;
  logic             apb_done;
  logic             apb_hit;
  logic [1:0]       sel;

  assign sel = {window_select_1_i, window_select_0_i};
  assign req = '{sel: psel_i, en: penable_i, wr: pwrite_i,
                 addr: paddr_i, wdata: pwdata_i};

  wwpl_kick_edge u_kick (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .kick_input_i (kick_input_i),
    .fall_o       (kick_fall)
  );

  // decode of the straps; held only when loaded into cfg
  always_comb begin
    dec = '0;
    dec.off = (sel == SEL_OFF);
    case (timeout_cap_pin_i)
      CAP_CAPACITOR: dec.upper = UPPER_CAP_CYC;
      CAP_PULLUP:    dec.upper = UPPER_PU_CYC;
      default:       dec.upper = UPPER_NC_CYC;
    endcase
    case (sel)
      SEL_HALF:    dec.lower = dec.upper >> SHIFT_HALF;
      SEL_QUARTER: dec.lower = dec.upper >> SHIFT_QUART;
      default:     dec.lower = dec.upper >> SHIFT_EIGHT;
    endcase
    case (delay_cap_pin_i)
      CAP_CAPACITOR: dec.rst_dly = DLY_CAP_CYC;
      CAP_PULLUP:    dec.rst_dly = DLY_PU_CYC;
      default:       dec.rst_dly = DLY_NC_CYC;
    endcase
  end

  // kicks only count while a window runs
  assign kick_live = kick_fall &&
                     (state == ST_CLOSED || state == ST_OPEN);

  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (cnt == INIT_CYC - 1) begin
          next_state = dec.off ? ST_DIS : ST_CLOSED;
        end
      end
      ST_DIS: begin
        if (!dec.off) begin
          next_state = ST_CLOSED;
        end
      end
      ST_CLOSED: begin
        if (dec.off) begin
          next_state = ST_DIS;
        end else if (kick_live) begin
          next_state = ST_FAULT;
        end else if (cnt == cfg.lower - 1) begin
          next_state = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (dec.off) begin
          next_state = ST_DIS;
        end else if (kick_live) begin
          next_state = ST_CLOSED;
        end else if (cnt == cfg.upper - 1) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (dec.off) begin
          next_state = ST_DIS;
        end else if (cnt == cfg.rst_dly - 1) begin
          next_state = ST_CLOSED;
        end
      end
      default: next_state = ST_INIT;
    endcase
  end

  // init end always latches, so the off flag is held in DIS entered from INIT; later entries keep cfg.off at 0
  assign cfg_load = (state == ST_INIT && next_state != ST_INIT) ||
                    (state == ST_DIS && next_state == ST_CLOSED);
  // the count runs on across the closed-to-open step
  assign restart  = (next_state != state) &&
                    !(state == ST_CLOSED && next_state == ST_OPEN);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (restart) begin
      cnt <= '0;
    end else if (state != ST_DIS) begin
      cnt <= cnt + 1'b1;
    end
  end

  // straps are taken at init end and on each DIS-to-CLOSED step, so a change mid-window cannot skew it
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= '0;
    end else if (cfg_load) begin
      cfg <= dec;
    end
  end

  // open drain: enable pulls low, output level itself is always 0
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reset_output_oe_o <= 1'b0;
      fault_reset_output_o    <= 1'b0;
    end else begin
      fault_reset_output_oe_o <= (next_state == ST_FAULT);
      fault_reset_output_o    <= 1'b0;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_EARLY]   = (state == ST_CLOSED) && next_state == ST_FAULT;
    ev[EV_LATE]    = (state == ST_OPEN) && next_state == ST_FAULT;
    ev[EV_RELEASE] = (state == ST_FAULT) && next_state == ST_CLOSED;
  end

  assign apb_done = req.sel && req.en && pready_o;
  assign apb_hit  = (req.addr == OFF_STATUS) ||
                    (req.addr == OFF_INT_STAT) ||
                    (req.addr == OFF_INT_MASK);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= req.sel && req.en && !pready_o;
      pslverr_o <= req.sel && req.en && !pready_o && !apb_hit;
      if (req.sel && req.en && !pready_o && !req.wr) begin
        case (req.addr)
          OFF_STATUS: begin
            prdata_o <= '0;
            prdata_o[ST_STATE_LSB +: 3] <= state;
            prdata_o[ST_DIS_BIT]        <= cfg.off | dec.off;
            prdata_o[ST_PIN_BIT]        <= fault_reset_output_i;
          end
          OFF_INT_STAT: prdata_o <= {{(DATA_W-EV_N){1'b0}}, int_stat};
          OFF_INT_MASK: prdata_o <= {{(DATA_W-EV_N){1'b0}}, int_mask};
          default:      prdata_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_mask <= INT_MASK_RST;
    end else if (apb_done && req.wr && req.addr == OFF_INT_MASK) begin
      int_mask <= req.wdata[EV_N-1:0];
    end
  end

  // read clears; an event in the same cycle survives the clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_stat <= '0;
    end else if (apb_done && !req.wr && req.addr == OFF_INT_STAT) begin
      int_stat <= ev;
    end else begin
      int_stat <= int_stat | ev;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((int_stat | ev) & int_mask);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fault_ends;
    state == ST_FAULT && !dec.off && cnt == cfg.rst_dly - 1;
  endsequence

  sequence s_released;
    ##1 (state == ST_CLOSED && cnt == '0);
  endsequence

  property p_early_kick;
    (state == ST_CLOSED && kick_fall && !dec.off)
      |=> (state == ST_FAULT && fault_reset_output_oe_o);
  endproperty
  a_early_kick: assert property (p_early_kick)
    else $error("early kick did not raise a timeout");

  property p_late_timeout;
    (state == ST_OPEN && !kick_fall && !dec.off &&
     cnt == cfg.upper - 1) |=> fault_reset_output_oe_o;
  endproperty
  a_late_timeout: assert property (p_late_timeout)
    else $error("missing kick did not raise a timeout");

  property p_kick_in_window;
    (state == ST_OPEN && kick_fall && !dec.off)
      |=> (state == ST_CLOSED && cnt == '0 && !fault_reset_output_oe_o);
  endproperty
  a_kick_in_window: assert property (p_kick_in_window)
    else $error("valid kick did not restart the window");

  property p_init_quiet;
    (state == ST_INIT && cnt != INIT_CYC - 1)
      |=> (state == ST_INIT && !fault_reset_output_oe_o);
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("watchdog left power-up sampling early");

  property p_init_exit;
    (state == ST_INIT && cnt == INIT_CYC - 1)
      |=> (state != ST_INIT && cfg.upper == $past(dec.upper) &&
           cfg.off == $past(dec.off));
  endproperty
  a_init_exit: assert property (p_init_exit)
    else $error("configuration not sampled at end of power-up");

  property p_off_quiet;
    (dec.off && state != ST_INIT)
      |=> (state == ST_DIS && !fault_reset_output_oe_o);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled straps did not hold the watchdog off");

  property p_dis_no_fault;
    (state == ST_DIS) |-> !fault_reset_output_oe_o;
  endproperty
  a_dis_no_fault: assert property (p_dis_no_fault)
    else $error("fault output asserted while disabled");

  property p_dis_ignores_kick;
    (state == ST_DIS && kick_fall && dec.off)
      |=> (state == ST_DIS && cnt == $past(cnt) &&
           !fault_reset_output_oe_o);
  endproperty
  a_dis_ignores_kick: assert property (p_dis_ignores_kick)
    else $error("kick acted while disabled");

  property p_fault_ignores_kick;
    (state == ST_FAULT && kick_fall && !dec.off &&
     cnt != cfg.rst_dly - 1) |=> (state == ST_FAULT && cnt == $past(cnt) + 1);
  endproperty
  a_fault_ignores_kick: assert property (p_fault_ignores_kick)
    else $error("kick disturbed the reset delay");

  property p_fault_hold;
    (state == ST_FAULT && cnt != cfg.rst_dly - 1 && !dec.off)
      |=> fault_reset_output_oe_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault output released before reset delay");

  property p_release_restart;
    s_fault_ends |-> s_released ##0 !fault_reset_output_oe_o;
  endproperty
  a_release_restart: assert property (p_release_restart)
    else $error("window did not restart at fault release");

  property p_read_clear;
    (apb_done && !req.wr && req.addr == OFF_INT_STAT && ev == '0)
      |=> int_stat == '0;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear the sticky bits");

endmodule

//--- sim/tb_top.sv
// self-checking bench: straps, kicks, fault pulses and apb registers
`timescale 1ns/1ps
module tb_top;
  import wwpl_pkg::*;
  localparam int LIMIT = 90000;
  logic        clock_i, rst_n_i, run, kick, psel, penable, pwrite;
  logic [15:0] per;
  logic [1:0]  sel, tcap, dcap;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, f_d, f_oe, f_w;
  int          fail_count, cmp_count, cyc, wid;
  logic [32:0] rd_q[$];
  int          pw_q[$];
  int          u_t[4] = '{200, 240, 280, 240};
  // capacitor delay runs at its default length, two long pulses
  int          d_t[4] = '{7030, 24, 28, 24};
  logic [1:0]  s_t[4] = '{2'h1, 2'h2, 2'h3, 2'h1};

  // pull-up on the open-drain wire
  assign f_w = f_oe ? f_d : 1'b1;

  wwpl_top #(
    .UPPER_CAP_CYC(32'h0000_00C8), .UPPER_NC_CYC(32'h0000_00F0),
    .UPPER_PU_CYC(32'h0000_0118),
    .DLY_NC_CYC(32'h0000_0018), .DLY_PU_CYC(32'h0000_001C)
  ) u_wwpl_top (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .kick_input_i(kick),
    .window_select_0_i(sel[0]), .window_select_1_i(sel[1]),
    .timeout_cap_pin_i(tcap), .delay_cap_pin_i(dcap),
    .fault_reset_output_i(f_w), .fault_reset_output_o(f_d),
    .fault_reset_output_oe_o(f_oe), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq)
  );

  wwpl_kicker u_wwpl_kicker (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run), .period_i(per),
    .kick_o(kick)
  );

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  function automatic logic [32:0] st(input logic [2:0] s, input logic dis);
    return {27'h0, 1'b1, dis, 1'b0, s};
  endfunction

  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    if (!wr) rd_q.push_back(e);
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // pready is read as it stood at the edge, before its own update
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for the fault pin; ends just after a rising edge
  task automatic wait_oe(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (f_oe !== v && n < lim);
    check("fault pin", {32'h0, f_oe}, {32'h0, v});
    check("fault data", {32'h0, f_d}, 33'h0);
    @(posedge clock_i);
  endtask

  // results appear here and are matched against the oldest note
  always @(negedge clock_i) begin
    if (psel && penable && pready && !pwrite) begin
      check("apb read", {pslverr, prdata},
            (rd_q.size() > 0) ? rd_q.pop_front() : 33'h1_FFFF_FFFF);
    end
    if (f_oe === 1'b1) begin
      wid++;
    end else if (wid != 0) begin
      // an unexpected pulse finds no note and fails
      check("fault width", 33'(wid),
            (pw_q.size() > 0) ? 33'(pw_q.pop_front()) : 33'h0);
      wid = 0;
    end
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    int l, u, d, p;
    void'($urandom(44235));
    {rst_n_i, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, tcap, dcap, sel} = '0;
    run = 1'b1;
    per = 16'h0025;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    w(100);
    apb(1'b0, OFF_STATUS, 32'h0, st(ST_INIT, 1'b1));
    w(INIT_CYC - 150);
    apb(1'b0, OFF_STATUS, 32'h0, st(ST_INIT, 1'b1));
    w(100);
    apb(1'b0, OFF_STATUS, 32'h0, st(ST_DIS, 1'b1));
    p = 12 + 4 * int'($urandom % 50);
    apb(1'b1, 8'(p), 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, 8'(p), 32'h0, 33'h1_0000_0000);
    apb(1'b0, OFF_INT_MASK, 32'h0, 33'h0);
    for (int i = 0; i < 4; i++) begin
      u = u_t[i];
      d = d_t[i];
      l = u >> s_t[i];
      apb(1'b1, OFF_INT_MASK, (i == 0) ? 32'h0 : 32'h7, 33'h0);
      apb(1'b0, OFF_INT_MASK, 32'h0, (i == 0) ? 33'h0 : 33'h7);
      run  <= 1'b0;
      tcap <= 2'(i);
      dcap <= 2'(i);
      w(4);
      // random kick period kept inside the open window
      p = l + 10 + int'($urandom % (u - l - 30));
      sel <= s_t[i];
      per <= 16'(p);
      run <= 1'b1;
      w(4 * p);
      pw_q.push_back(d);
      run <= 1'b0;
      wait_oe(1'b1, u + 40);
      @(negedge clock_i);
      check("irq", {32'h0, irq}, {32'h0, i != 0});
      wait_oe(1'b0, d + 8);
      pw_q.push_back(d);
      per <= 16'(l / 2);
      run <= 1'b1;
      apb(1'b0, OFF_INT_STAT, 32'h0, 33'h6);
      wait_oe(1'b1, l + 20);
      run <= 1'b0;
      w(2);
      per <= 16'h0006;
      run <= 1'b1;
      w(8);
      run <= 1'b0;
      wait_oe(1'b0, d);
      per <= 16'(p);
      run <= 1'b1;
      apb(1'b0, OFF_INT_STAT, 32'h0, 33'h5);
      w(SET_CYC);
      sel <= 2'h0;
      w(SET_CYC);
      apb(1'b0, OFF_STATUS, 32'h0, st(ST_DIS, 1'b1));
      @(negedge clock_i);
      check("irq", {32'h0, irq}, 33'h0);
    end
    check("pending", 33'(rd_q.size() + pw_q.size()), 33'h0);
    end_of_test();
  end
endmodule

//--- sim/wwpl_kicker.sv
// partner model: supervised cpu that produces kick falling edges
`timescale 1ns/1ps
module wwpl_kicker (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic [15:0] period_i,
  output logic             kick_o
);
  logic [15:0] cnt;
  logic [3:0]  low;

  // idle level is driven high, never left floating
  assign kick_o = (low == 4'h0);

  // one falling edge per period of 9 cycles or more, held low long enough for the synchroniser
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
      low <= 4'h0;
    end else if (!run_i) begin
      cnt <= 16'h0000;
      low <= 4'h0;
    end else if (cnt == period_i - 16'h0001) begin
      cnt <= 16'h0000;
      low <= 4'h8;
    end else begin
      cnt <= cnt + 16'h0001;
      if (low != 4'h0) low <= low - 4'h1;
    end
  end
endmodule
